// File: hdl/nals_lane_steer.sv
`timescale 1ns/100ps
`include "nals_params.svh"

module nals_lane_steer import nals_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // width of the attached memory, static while accesses run
    input wire nals_width_e mem_width_in,
    // processor read bus
    input wire logic cpu_rd_valid_in,
    input wire nals_req_s cpu_rd_req_in,
    output logic cpu_rd_ready_out,
    output logic cpu_rd_done_out,
    output logic [`NALS_RES_W-1:0] cpu_rd_data_out,
    // processor write bus
    input wire logic cpu_wr_valid_in,
    input wire nals_req_s cpu_wr_req_in,
    output logic cpu_wr_ready_out,
    output logic cpu_wr_done_out,
    // dma controller
    input wire logic dma_valid_in,
    input wire nals_req_s dma_req_in,
    output logic dma_ready_out,
    output logic dma_done_out,
    output logic [`NALS_RES_W-1:0] dma_rd_data_out,
    // refused access, pulses with the done of its requester
    output logic req_error_out,
    // transfer toward the memory timing stage
    output logic xfer_valid_out,
    input wire logic xfer_ready_in,
    output nals_xfer_s xfer_out,
    input wire logic xfer_done_in,
    input wire logic [`NALS_DATA_W-1:0] xfer_rdata_in,
    // external byte enables, active low
    output logic byte_lane0_enable_n_out,
    output logic byte_lane1_enable_n_out,
    output logic byte_lane2_enable_n_out,
    output logic byte_lane3_enable_n_out
);

////////////////////////////////////////////////////////////
// state, next state and reset value
// sits between three requesters and the timing stage
// one narrow request becomes one or two beats
// only one access is in flight at a time, so one
// record holds request, beat count, result and pins
// every output that reaches a pin comes from it
// requesters see ready, done and read data
// the memory side sees one beat at a time
// latency depends only on how fast beats are taken and done

nals_state_s st;
nals_state_s next_st;

// idle transfer: nothing enabled, data pins released
// all enables high: no stray lane select when idle
// data pins released so the bus is never fought
localparam nals_xfer_s XFER_IDLE = '{
    addr: '0,
    wdata: '0,
    write: 1'h0,
    data_oe_n: 1'h1,
    be_n: `NALS_BE_IDLE
};

// empty request, loaded at reset only
localparam nals_req_s REQ_NONE = '{
    addr: '0,
    size: NALS_SZ_BYTE,
    write: 1'h0,
    wdata: '0
};

// reset record: idle, pins quiet, result cleared
// source is a don't-care until the first take
localparam nals_state_s ST_RESET = '{
    state: NALS_ST_IDLE,
    src: NALS_SRC_CPU_RD,
    width: NALS_MW8,
    op: REQ_NONE,
    beat: 1'h0,
    error: 1'h0,
    hi_byte: 8'h00,
    result: 16'h0000,
    xfer: XFER_IDLE
};

////////////////////////////////////////////////////////////
// lane steering for the access in progress
// pure decoding of the held request
// loaded into the record only in setup,
// so the pins never see a decoding glitch
// the extracted byte comes straight off the
// returned data in the cycle of done

logic [3:0] map_be_n;
logic [`NALS_DATA_W-1:0] map_wdata;
nals_addr_t map_addr;
logic [7:0] map_byte;

nals_lane_map u_lane_map (
    .width_in(st.width),
    .op_in(st.op),
    .beat_in(st.beat),
    .rdata_in(xfer_rdata_in),
    .be_n_out(map_be_n),
    .wdata_out(map_wdata),
    .addr_out(map_addr),
    .byte_out(map_byte)
);

////////////////////////////////////////////////////////////
// request arbitration

// fixed priority: processor read, processor write, dma
// a valid held high can starve lower requesters
// processor reads go first, they stall the core
// grants only in idle: late requests just wait
// the grants exclude each other by construction,
// which the sequencer relies upon
logic idle;
logic grant_rd;
logic grant_wr;
logic grant_dma;

assign idle = (st.state == NALS_ST_IDLE);
assign grant_rd = idle && cpu_rd_valid_in;
assign grant_wr = idle && cpu_wr_valid_in && !cpu_rd_valid_in;
assign grant_dma = idle && dma_valid_in && !cpu_rd_valid_in && !cpu_wr_valid_in;

// a request is taken on the edge where its ready is high
// combinational readies lose no cycle on a take
assign cpu_rd_ready_out = grant_rd;
assign cpu_wr_ready_out = grant_wr;
assign dma_ready_out = grant_dma;

////////////////////////////////////////////////////////////
// access checks

// true when this block cannot carry the access out
// a refused access never reaches the timing stage
// it answers with error beside its done, so the
// requester is never left waiting
// judged on the width sampled at the take
// wide-memory halfwords belong to the full path
// and are refused rather than split into beats
function automatic logic refuse(nals_width_e w, nals_req_s r);
    logic bad;
    bad = 1'h0;
    // writes to byte-wide memory are not supported
    if (r.write && (w == NALS_MW8)) begin
        bad = 1'h1;
    end
    // halfwords to wider memory belong to the full-width path
    if ((r.size == NALS_SZ_HALF) && (w != NALS_MW8)) begin
        bad = 1'h1;
    end
    // halfword writes are never sequenced here
    if ((r.size == NALS_SZ_HALF) && r.write) begin
        bad = 1'h1;
    end
    // reserved width code
    if ((w != NALS_MW8) && (w != NALS_MW16) && (w != NALS_MW32)) begin
        bad = 1'h1;
    end
    refuse = bad;
endfunction : refuse

////////////////////////////////////////////////////////////
// sequencer

// chosen request, with the write bit set by the bus it came on
// processor direction is given by the bus used,
// so those write bits are overridden here
// the dma request brings its own direction
nals_req_s pick;

always_comb begin
    pick = dma_req_in;
    if (grant_rd) begin
        pick = cpu_rd_req_in;
        pick.write = 1'h0;
    end else if (grant_wr) begin
        pick = cpu_wr_req_in;
        pick.write = 1'h1;
    end
end

// next-state logic for the whole block
// idle: wait for a grant, latch request, width
// setup: load address, data, enables of a beat
// issue: offer the beat until it is taken
// wait: collect the data of that beat
// reply: pulse done one cycle, back to idle
// halfword from byte memory runs setup-wait twice
// a byte needs four cycles at least, a half seven
// width is not re-read during an access, so a
// strap change mid-access cannot split a beat
always_comb begin
    next_st = st;
    case (st.state)
        NALS_ST_IDLE: begin
            if (grant_rd || grant_wr || grant_dma) begin
                next_st.op = pick;
                next_st.width = mem_width_in;
                next_st.beat = 1'h0;
                next_st.result = 16'h0000;
                next_st.error = refuse(mem_width_in, pick);
                if (grant_rd) begin
                    next_st.src = NALS_SRC_CPU_RD;
                end else if (grant_wr) begin
                    next_st.src = NALS_SRC_CPU_WR;
                end else begin
                    next_st.src = NALS_SRC_DMA;
                end
                // a refused access answers without touching memory
                // and skips setup: no enable goes low
                if (next_st.error) begin
                    next_st.state = NALS_ST_REPLY;
                end else begin
                    next_st.state = NALS_ST_SETUP;
                end
            end
        end
        NALS_ST_SETUP: begin
            // load the steered beat into the output registers
            // a second beat keeps the first's enables
            // through here, so lane zero stays low
            next_st.xfer.addr = map_addr;
            next_st.xfer.wdata = map_wdata;
            next_st.xfer.write = st.op.write;
            next_st.xfer.data_oe_n = !st.op.write;
            next_st.xfer.be_n = map_be_n;
            next_st.state = NALS_ST_ISSUE;
        end
        NALS_ST_ISSUE: begin
            // beat stands unchanged until taken
            // the timing stage may stall it long
            if (xfer_ready_in) begin
                next_st.state = NALS_ST_WAIT;
            end
        end
        NALS_ST_WAIT: begin
            if (xfer_done_in) begin
                if ((st.op.size == NALS_SZ_HALF) && !st.beat) begin
                    // first byte kept as the upper half, go for the next
                    // next address is the first plus one
                    next_st.hi_byte = map_byte;
                    next_st.beat = 1'h1;
                    next_st.state = NALS_ST_SETUP;
                end else begin
                    // writes return nothing; reads give a
                    // zero-extended byte or a packed half
                    if (st.op.write) begin
                        next_st.result = st.result;
                    end else if (st.op.size == NALS_SZ_HALF) begin
                        next_st.result = {st.hi_byte, map_byte};
                    end else begin
                        next_st.result = {8'h00, map_byte};
                    end
                    next_st.xfer = XFER_IDLE;
                    next_st.state = NALS_ST_REPLY;
                end
            end
        end
        NALS_ST_REPLY: begin
            // one cycle: done and error pulse here
            next_st.xfer = XFER_IDLE;
            next_st.state = NALS_ST_IDLE;
        end
        default: begin
            // an illegal code recovers to reset
            next_st = ST_RESET;
        end
    endcase
end

// state register
// asynchronous reset: pins quiet before the clock
// every field resets at once, none powers up unknown
always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
        st <= ST_RESET;
    end else begin
        st <= next_st;
    end
end

////////////////////////////////////////////////////////////
// outputs

// done pulses last the one reply cycle
// decodes of registered state: glitch free
// error only qualifies a done, never alone
logic reply;

assign reply = (st.state == NALS_ST_REPLY);
assign cpu_rd_done_out = reply && (st.src == NALS_SRC_CPU_RD);
assign cpu_wr_done_out = reply && (st.src == NALS_SRC_CPU_WR);
assign dma_done_out = reply && (st.src == NALS_SRC_DMA);
assign req_error_out = reply && st.error;

// read data from the result register, held until the next request is taken
// both requesters share it; only the one whose
// done pulses should take it
// a write leaves it cleared, so stale data is
// never shown as a fresh reply
assign cpu_rd_data_out = st.result;
assign dma_rd_data_out = st.result;

// transfer request toward the timing stage
// valid is high for the whole issue state
// fields hold while valid, any edge may take them
assign xfer_valid_out = (st.state == NALS_ST_ISSUE);
assign xfer_out = st.xfer;

// byte enables straight from the transfer register
// no logic before the pins: all four switch
// together on one clock edge
assign byte_lane0_enable_n_out = st.xfer.be_n[0];
assign byte_lane1_enable_n_out = st.xfer.be_n[1];
assign byte_lane2_enable_n_out = st.xfer.be_n[2];
assign byte_lane3_enable_n_out = st.xfer.be_n[3];

endmodule : nals_lane_steer

// File: shared/nals_params.svh
`ifndef NALS_PARAMS_SVH
`define NALS_PARAMS_SVH
// Overview of operation
// - halfword from byte memory: two byte beats
// - second beat address is first plus one
// - first byte is high half, second low
// - byte memory beats use lane zero only
// - byte memory halfword: only lane zero enabled
// - reply only after both bytes are packed
// - byte reads any width, writes 16/32 only
// - byte write one lane, read full width
// - byte read of 32-bit memory: full access
// - 32-bit memory byte write: lowest line A2
// - 32-bit lanes: code 00 top, 11 bottom
// - 32-bit byte write: one enable low only
// - byte read of 16-bit memory: 16-bit access
// - 16-bit memory byte write: lowest line A1
// - 16-bit write: bit0 zero upper, one lower
// - byte memory read: lane zero, lowest A0
// - byte memory read: only lane zero enabled
// - processor reads/writes use own data buses
// - 16-bit memory read: lower two enables low
// - full 32-bit access: all enables low

// address, data and result widths
`define NALS_ADDR_W 22
`define NALS_DATA_W 32
`define NALS_RES_W 16
// byte enable levels, active low, bit n is lane n
`define NALS_BE_IDLE 4'hF
`define NALS_BE_ALL 4'h0
`define NALS_BE_LOW16 4'hC
`define NALS_BE_LANE0 4'hE
// lowest address line kept per memory width
`define NALS_MASK_W32 22'h3FFFFC
`define NALS_MASK_W16 22'h3FFFFE
`endif

// File: shared/nals_pkg.sv
package nals_pkg;
`include "nals_params.svh"

// external memory width strap
typedef enum logic [1:0] {
    NALS_MW8 = 2'h0,
    NALS_MW16 = 2'h1,
    NALS_MW32 = 2'h2
} nals_width_e;

// requested data size
typedef enum logic {
    NALS_SZ_BYTE = 1'h0,
    NALS_SZ_HALF = 1'h1
} nals_size_e;

// requester that owns the current access
typedef enum logic [2:0] {
    NALS_SRC_CPU_RD = 3'h1,
    NALS_SRC_CPU_WR = 3'h2,
    NALS_SRC_DMA = 3'h4
} nals_src_e;

// sequencer states
typedef enum logic [4:0] {
    NALS_ST_IDLE = 5'h01,
    NALS_ST_SETUP = 5'h02,
    NALS_ST_ISSUE = 5'h04,
    NALS_ST_WAIT = 5'h08,
    NALS_ST_REPLY = 5'h10
} nals_state_e;

typedef logic [`NALS_ADDR_W-1:0] nals_addr_t;

// one internal request
typedef struct packed {
    nals_addr_t addr;
    nals_size_e size;
    logic write;
    logic [`NALS_RES_W-1:0] wdata;
} nals_req_s;

// one byte-lane transfer toward the memory timing stage
typedef struct packed {
    nals_addr_t addr;
    logic [`NALS_DATA_W-1:0] wdata;
    logic write;
    logic data_oe_n;
    logic [3:0] be_n;
} nals_xfer_s;

// whole sequencer state
typedef struct packed {
    nals_state_e state;
    nals_src_e src;
    nals_width_e width;
    nals_req_s op;
    logic beat;
    logic error;
    logic [7:0] hi_byte;
    logic [`NALS_RES_W-1:0] result;
    nals_xfer_s xfer;
} nals_state_s;

endpackage : nals_pkg

// File: hdl/nals_lane_map.sv
`timescale 1ns/100ps
`include "nals_params.svh"

module nals_lane_map import nals_pkg::*; (
    input wire nals_width_e width_in,
    input wire nals_req_s op_in,
    input wire logic beat_in,
    input wire logic [`NALS_DATA_W-1:0] rdata_in,
    output logic [3:0] be_n_out,
    output logic [`NALS_DATA_W-1:0] wdata_out,
    output nals_addr_t addr_out,
    output logic [7:0] byte_out
);

// byte lane picked by the low address bits, shared by reads and writes
function automatic logic [1:0] lane_of(nals_width_e w, logic [1:0] a);
    case (w)
        NALS_MW32: lane_of = ~a;
        NALS_MW16: lane_of = {1'h0, ~a[0]};
        default: lane_of = 2'h0;
    endcase
endfunction : lane_of

logic [1:0] lane;
nals_addr_t half_addr;

// lane, address and enable steering for the current beat
always_comb begin
    lane = lane_of(width_in, op_in.addr[1:0]);
    half_addr = {op_in.addr[`NALS_ADDR_W-1:1], 1'h0} + nals_addr_t'(beat_in);
    byte_out = rdata_in[{lane, 3'h0} +: 8];
    wdata_out = '0;
    wdata_out[{lane, 3'h0} +: 8] = op_in.wdata[7:0];
    if (width_in == NALS_MW32) begin
        addr_out = op_in.addr & `NALS_MASK_W32;
        be_n_out = op_in.write ? ~(4'h1 << lane) : `NALS_BE_ALL;
    end else if (width_in == NALS_MW16) begin
        addr_out = op_in.addr & `NALS_MASK_W16;
        be_n_out = op_in.write ? ~(4'h1 << lane) : `NALS_BE_LOW16;
    end else begin
        addr_out = (op_in.size == NALS_SZ_HALF) ? half_addr : op_in.addr;
        be_n_out = `NALS_BE_LANE0;
    end
end

endmodule : nals_lane_map

// File: verification/nals_mem_model.sv
`timescale 1ns/100ps
module nals_mem_model import nals_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [1:0] slow_in,
    input wire logic xfer_valid_in,
    input wire nals_xfer_s xfer_in,
    output logic xfer_ready_out,
    output logic xfer_done_out,
    output logic [31:0] xfer_rdata_out
);
    logic [1:0] cnt;
    nals_addr_t la;
    logic [3:0] lb;
    // fixed contents, each lane a different function of the address
    function automatic logic [31:0] word(input nals_addr_t a);
        return {a[7:0] ^ 8'h3C, a[7:0] + 8'h47, ~a[7:0], a[7:0] ^ a[15:8]};
    endfunction : word
    // accept after slow_in idle cycles, finish one cycle later
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt <= 2'h0;
            xfer_ready_out <= 1'b0;
            xfer_done_out <= 1'b0;
            la <= '0;
            lb <= 4'hF;
        end else begin
            xfer_ready_out <= 1'b0;
            xfer_done_out <= xfer_ready_out && xfer_valid_in;
            if (xfer_ready_out && xfer_valid_in) begin
                la <= xfer_in.addr;
                lb <= xfer_in.be_n;
            end
            if (xfer_valid_in && !xfer_ready_out && !xfer_done_out) begin
                if (cnt >= slow_in) begin
                    xfer_ready_out <= 1'b1;
                    cnt <= 2'h0;
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end
        end
    end
    // disabled lanes and idle cycles carry no valid data
    assign xfer_rdata_out = xfer_done_out ?
        word(la) ^ {{8{lb[3]}}, {8{lb[2]}}, {8{lb[1]}}, {8{lb[0]}}} : ~word(la);
endmodule : nals_mem_model

// File: verification/nals_lane_steer_props.sv
`timescale 1ns/100ps
module nals_lane_steer_chk import nals_pkg::*; (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire nals_width_e mem_width_in,
    input wire logic xfer_valid_out,
    input wire logic xfer_ready_in,
    input wire nals_xfer_s xfer_out,
    input wire logic byte_lane0_enable_n_out,
    input wire logic byte_lane1_enable_n_out,
    input wire logic byte_lane2_enable_n_out,
    input wire logic byte_lane3_enable_n_out,
    input wire logic cpu_rd_done_out,
    input wire logic cpu_wr_done_out,
    input wire logic dma_done_out,
    input wire logic req_error_out
);
    logic [3:0] be;
    logic [31:0] lm;
    logic dn;
    logic pend;
    nals_addr_t last;
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);
    // enable pins, lanes a write may touch, any reply
    assign be = {byte_lane3_enable_n_out, byte_lane2_enable_n_out,
        byte_lane1_enable_n_out, byte_lane0_enable_n_out};
    assign lm = {{8{~be[3]}}, {8{~be[2]}}, {8{~be[1]}}, {8{~be[0]}}};
    assign dn = cpu_rd_done_out | cpu_wr_done_out | dma_done_out;
    // last accepted beat address, pending until the reply
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pend <= 1'b0;
            last <= '0;
        end else if (xfer_valid_out && xfer_ready_in) begin
            pend <= 1'b1;
            last <= xfer_out.addr;
        end else if (dn) begin
            pend <= 1'b0;
        end
    end
    ////////////////////////////////////////
    a_byte_mem_hold: assert property (pend && !xfer_valid_out && !dn
        && mem_width_in == NALS_MW8 |-> be == 4'hE) else $error("byte memory enables dropped");
    a_beat_holds: assert property (xfer_valid_out && !xfer_ready_in
        |=> xfer_valid_out && $stable(xfer_out)) else $error("beat changed while waiting");
    a_write_one_lane: assert property (xfer_valid_out && xfer_out.write
        |-> $onehot(~be) && !xfer_out.data_oe_n && (xfer_out.wdata & ~lm) == 32'h0)
        else $error("write lane wrong");
    a_byte_mem_lane: assert property (xfer_valid_out && mem_width_in == NALS_MW8
        |-> be == 4'hE && !xfer_out.write) else $error("byte memory beat wrong");
    a_half_mem_read: assert property (xfer_valid_out && mem_width_in == NALS_MW16
        && !xfer_out.write |-> be == 4'hC && !xfer_out.addr[0]) else $error("16 read wrong");
    a_full_mem_read: assert property (xfer_valid_out && mem_width_in == NALS_MW32
        && !xfer_out.write |-> be == 4'h0 && xfer_out.addr[1:0] == 2'h0)
        else $error("32 read wrong");
    a_w32_line: assert property (xfer_valid_out && mem_width_in == NALS_MW32
        && xfer_out.write |-> xfer_out.addr[1:0] == 2'h0) else $error("32 write line wrong");
    a_w16_line: assert property (xfer_valid_out && mem_width_in == NALS_MW16
        && xfer_out.write |-> !xfer_out.addr[0] && be[3:2] == 2'h3)
        else $error("16 write line wrong");
    a_second_beat: assert property ($rose(xfer_valid_out) && pend
        |-> xfer_out.addr == last + 22'h1 && !last[0] && mem_width_in == NALS_MW8)
        else $error("second beat address wrong");
    a_reply_release: assert property (dn |-> be == 4'hF ##1 !dn)
        else $error("reply not released");
    a_error_done: assert property (req_error_out |-> dn)
        else $error("error without reply");
endmodule : nals_lane_steer_chk

bind nals_lane_steer nals_lane_steer_chk u_chk (.clk_sys_in, .reset_n_in, .mem_width_in,
    .xfer_valid_out, .xfer_ready_in, .xfer_out, .byte_lane0_enable_n_out,
    .byte_lane1_enable_n_out, .byte_lane2_enable_n_out, .byte_lane3_enable_n_out,
    .cpu_rd_done_out, .cpu_wr_done_out, .dma_done_out, .req_error_out);

// File: verification/test_narrow_access_lane_steering.sv
`timescale 1ns/100ps
module test_narrow_access_lane_steering import nals_pkg::*;;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    nals_width_e mem_width_in = NALS_MW32;
    logic [2:0] vld = 3'h0;
    nals_req_s rq = '0;
    logic [1:0] slow = 2'h0;
    logic xfer_ready_in, xfer_done_in, xfer_valid_out, req_error_out;
    logic [31:0] xfer_rdata_in;
    logic [2:0] rdy, dn;
    logic [15:0] rd_cpu, rd_dma;
    nals_xfer_s xfer_out;
    logic [3:0] be;
    nals_xfer_s got[$];
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h51;

    nals_lane_steer u_dut (.clk_sys_in, .reset_n_in, .mem_width_in,
        .cpu_rd_valid_in(vld[0]), .cpu_rd_req_in(rq), .cpu_rd_ready_out(rdy[0]),
        .cpu_rd_done_out(dn[0]), .cpu_rd_data_out(rd_cpu),
        .cpu_wr_valid_in(vld[1]), .cpu_wr_req_in(rq), .cpu_wr_ready_out(rdy[1]),
        .cpu_wr_done_out(dn[1]), .dma_valid_in(vld[2]), .dma_req_in(rq),
        .dma_ready_out(rdy[2]), .dma_done_out(dn[2]), .dma_rd_data_out(rd_dma),
        .req_error_out, .xfer_valid_out, .xfer_ready_in, .xfer_out, .xfer_done_in,
        .xfer_rdata_in, .byte_lane0_enable_n_out(be[0]), .byte_lane1_enable_n_out(be[1]),
        .byte_lane2_enable_n_out(be[2]), .byte_lane3_enable_n_out(be[3]));
    nals_mem_model u_mem (.clk_sys_in, .reset_n_in, .slow_in(slow),
        .xfer_valid_in(xfer_valid_out), .xfer_in(xfer_out), .xfer_ready_out(xfer_ready_in),
        .xfer_done_out(xfer_done_in), .xfer_rdata_out(xfer_rdata_in));

    always #10 clk_sys_in = ~clk_sys_in;
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    // record accepted beats with the pin levels; read data lanes ignored
    always @(negedge clk_sys_in) begin
        if (xfer_valid_out && xfer_ready_in) got.push_back('{xfer_out.addr,
            xfer_out.write ? xfer_out.wdata : 32'h0, xfer_out.write, xfer_out.data_oe_n, be});
    end
    // hang guard
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    // one access from requester s, with beats and reply checked
    task automatic access(input int s, input nals_width_e w, input nals_req_s r);
        nals_xfer_s ex[$];
        logic wr, ee;
        logic [1:0] ln;
        logic [3:0] eb;
        nals_addr_t la;
        logic [31:0] m;
        logic [15:0] er;
        int k;
        wr = s == 1 || (s == 2 && r.write);
        ee = w == 2'h3 || (wr && w == NALS_MW8) || (r.size && (w != NALS_MW8 || wr));
        ln = w == NALS_MW32 ? ~r.addr[1:0] : w == NALS_MW16 ? {1'b0, ~r.addr[0]} : 2'h0;
        la = w == NALS_MW32 ? r.addr & 22'h3FFFFC : r.addr & {21'h1FFFFF, w == NALS_MW8};
        if (r.size) la[0] = 1'b0;
        eb = wr ? ~(4'h1 << ln) : w == NALS_MW32 ? 4'h0 : w == NALS_MW16 ? 4'hC : 4'hE;
        m = u_mem.word(la);
        er = {8'h00, m[8 * ln +: 8]};
        if (!ee && r.size) begin
            ex.push_back('{la, 32'h0, 1'b0, 1'b1, 4'hE});
            ex.push_back('{la + 22'h1, 32'h0, 1'b0, 1'b1, 4'hE});
            m = u_mem.word(la + 22'h1);
            er = {er[7:0], m[7:0]};
        end else if (!ee) begin
            ex.push_back('{la, wr ? {24'h0, r.wdata[7:0]} << 8 * ln : 32'h0, wr, ~wr, eb});
        end
        got.delete();
        @(posedge clk_sys_in);
        mem_width_in <= w;
        rq <= r;
        vld[s] <= 1'b1;
        k = 0;
        do begin
            @(negedge clk_sys_in);
            k++;
        end while (!rdy[s] && k < 50);
        @(posedge clk_sys_in);
        vld[s] <= 1'b0;
        k = 0;
        while (!dn[s] && k < 200) begin
            @(negedge clk_sys_in);
            k++;
        end
        chk("beats", ex.size(), got.size());
        chk("error", ee, req_error_out);
        for (int i = 0; i < ex.size(); i++) chk("beat", ex[i], got[i]);
        if (!ee && !wr) chk("data", er, s == 0 ? rd_cpu : rd_dma);
    endtask : access
    // lane corner cases per width, then random traffic, then a second reset
    initial begin
        nals_req_s r;
        logic [31:0] m;
        repeat (16) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        for (int w = 0; w < 4; w++) begin
            for (int a = 0; a < 8; a++) begin
                for (int s = 0; s < 3; s++) begin
                    r = '{22'h2C40 + a, nals_size_e'(a[2]), s == 2, 16'hA500 + a};
                    access(s, nals_width_e'(w), r);
                end
            end
        end
        repeat (300) begin
            m = rnd();
            r = '{m[21:0], nals_size_e'(m[22]), m[23], m[31:16]};
            slow <= m[25:24];
            access(m[29:28] % 3, nals_width_e'(m[27:26]), r);
        end
        // reset while a 32-bit read beat is on the pins
        @(posedge clk_sys_in);
        mem_width_in <= NALS_MW32;
        rq <= '{22'h0101, NALS_SZ_BYTE, 1'b0, 16'h0000};
        vld[0] <= 1'b1;
        @(posedge clk_sys_in);
        vld[0] <= 1'b0;
        repeat (2) @(negedge clk_sys_in);
        chk("beat enables", 4'h0, be);
        reset_n_in <= 1'b0;
        @(negedge clk_sys_in);
        chk("idle enables", 4'hF, be);
        chk("idle valid", 1'b0, xfer_valid_out);
        reset_n_in <= 1'b1;
        access(0, NALS_MW8, '{22'h0013, NALS_SZ_HALF, 1'b0, 16'h0000});
        summarize();
    end
endmodule : test_narrow_access_lane_steering
